/* hbeu_map.svh */
`ifndef HBEU_MAP_SVH
`define HBEU_MAP_SVH

// ----------------------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------------------
`define HBEU_OFS_CTRL      8'h00
`define HBEU_OFS_ORDER     8'h04
`define HBEU_OFS_ADDR1     8'h08
`define HBEU_OFS_ADDR2     8'h0C
`define HBEU_OFS_TCOUNT    8'h10
`define HBEU_OFS_STATUS    8'h14
`define HBEU_OFS_MASK      8'h18
`define HBEU_OFS_TIMER     8'h1C
`define HBEU_OFS_ROM_ADDR  8'h20
`define HBEU_OFS_ROM_DATA  8'h24
`define HBEU_OFS_RUN       8'h28

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define HBEU_CTRL_COMB_LO  0
`define HBEU_CTRL_EN_A1    2
`define HBEU_CTRL_EN_A2    3
`define HBEU_CTRL_EN_T     4
`define HBEU_CTRL_SRC_BP   5
`define HBEU_CTRL_SRC_STK  6
`define HBEU_CTRL_SRC_TEV  7
`define HBEU_CTRL_SRC_TFL  8
`define HBEU_CTRL_TMODE_LO 9
`define HBEU_CTRL_CYCSRC   11
`define HBEU_CTRL_TRIG_LOW 12
`define HBEU_CTRL_WIDTH    13

// Sequence slot codes.
`define HBEU_SLOT_A1       2'h0
`define HBEU_SLOT_A2       2'h1
`define HBEU_SLOT_T        2'h2
`define HBEU_SLOT_NONE     2'h3

// ----------------------------------------------------------------------------
// Reset values, sizes and timing
// ----------------------------------------------------------------------------
`define HBEU_CTRL_RST      13'h0_000
`define HBEU_ORDER_RST     6'h3_C
`define HBEU_TCOUNT_MIN    16'h0_002
`define HBEU_TCOUNT_RST    16'h0_002
`define HBEU_NOP_CODE      10'h0_00
`define HBEU_ROM_AW        12
`define HBEU_ROM_DEPTH     4096
`define HBEU_INSN_W        10
`define HBEU_TICK_US       10
`define HBEU_CLK_MHZ       10
`define HBEU_TICK_CYC      (`HBEU_TICK_US * `HBEU_CLK_MHZ)

`endif

/* hbeu_pkg.sv */
package hbeu_pkg;

    typedef enum logic [1:0] {COMB_AND, COMB_OR, COMB_SEQ, COMB_RSVD} hbeu_comb_t;

    typedef enum logic [1:0] {
        timer_off_mode,
        timeout_mode,
        elapsed_run_mode,
        post_event_delay_mode
    } hbeu_tmode_t;

    typedef enum logic [1:0] {ST_FILL, ST_IDLE, ST_RUN, ST_HALT} hbeu_phase_t;

    // Signals observed on the target MCU under debug.
    typedef struct packed {
        logic        run_start;
        logic        mcu_cycle;
        logic        fetch_valid;
        logic [11:0] fetch_addr;
        logic        trig;
        logic        stk_ovf;
        logic        stk_unf;
        logic        trace_ev;
        logic        trace_full;
    } hbeu_tgt_t;

    typedef struct packed {
        logic [31:0] wdata;
        logic [7:0]  addr;
        logic        we;
        logic        re;
    } hbeu_bus_t;

endpackage : hbeu_pkg

/* hbeu_top.sv */
`timescale 1ns/1ps
`include "hbeu_map.svh"

module hbeu_top (
    input  wire logic                clk,
    input  wire logic                reset_n,
    input  wire hbeu_pkg::hbeu_bus_t bus,
    output logic [31:0]              rdata,
    input  wire hbeu_pkg::hbeu_tgt_t tgt,
    output logic [9:0]               fetch_data,
    output logic                     halt,
    output logic                     init_busy,
    output logic                     irq
);
    import hbeu_pkg::*;

    // ------------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------------
    typedef struct packed {
        hbeu_phase_t phase;
        logic [12:0] ctrl;
        logic [5:0]  order;
        logic [11:0] addr1;
        logic [11:0] addr2;
        logic [15:0] tcount;
        logic [5:0]  status;
        logic [5:0]  mask;
        logic [11:0] rom_addr;
        logic [11:0] fill_addr;
        logic [6:0]  tick_cnt;
        logic [15:0] tmr_cnt;
        logic        tmr_run;
        logic        tmr_exp;
        logic [1:0]  seq_step;
        logic [4:0]  cause;
        logic [31:0] rdata;
        logic [9:0]  fetch_data;
        logic        halt;
        logic        irq;
        logic        busy;
    } hbeu_state_t;

    localparam logic [6:0]  TICK_LAST = 7'(`HBEU_TICK_CYC - 1);
    localparam logic [11:0] ROM_LAST  = 12'(`HBEU_ROM_DEPTH - 1);

    hbeu_state_t s_q;
    hbeu_state_t s_d;
    logic [1:0]  rst_sync_q;
    logic        rst_n;

    // ------------------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------------------
    // The state register leaves reset on one edge, two flops after the pin.
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rst_sync_q <= 2'h0;
        end
        else
        begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    // ------------------------------------------------------------------------
    // Emulated program ROM
    // ------------------------------------------------------------------------
    // The array has no reset; its content is defined by the fill pass, which
    // runs before the target may execute.
    logic [`HBEU_INSN_W-1:0] rom [`HBEU_ROM_DEPTH];
    logic                    mem_we;
    logic [11:0]             mem_wa;
    logic [9:0]              mem_wd;
    logic [9:0]              rom_rd;

    // One write port, shared by the fill pass and software downloads.
    always_ff @(posedge clk)
    begin
        if (mem_we)
        begin
            rom[mem_wa] <= mem_wd;
        end
    end
    assign rom_rd = rom[tgt.fetch_addr];

    // ------------------------------------------------------------------------
    // Decoded controls
    // ------------------------------------------------------------------------
    hbeu_comb_t  comb_mode;
    hbeu_tmode_t tmode;
    logic        en_a1;
    logic        en_a2;
    logic        en_t;
    logic        hit_a1;
    logic        hit_a2;
    logic        hit_t;
    logic [2:0]  hits;
    logic [2:0]  ens;

    always_comb
    begin
        comb_mode = hbeu_comb_t'(s_q.ctrl[`HBEU_CTRL_COMB_LO +: 2]);
        tmode     = hbeu_tmode_t'(s_q.ctrl[`HBEU_CTRL_TMODE_LO +: 2]);
        en_a1     = s_q.ctrl[`HBEU_CTRL_EN_A1];
        en_a2     = s_q.ctrl[`HBEU_CTRL_EN_A2];
        en_t      = s_q.ctrl[`HBEU_CTRL_EN_T];
        hit_a1    = tgt.fetch_valid && (tgt.fetch_addr == s_q.addr1);
        hit_a2    = tgt.fetch_valid && (tgt.fetch_addr == s_q.addr2);
        // The polarity bit flips the pin, so both levels share one compare.
        hit_t     = tgt.trig ^ s_q.ctrl[`HBEU_CTRL_TRIG_LOW];
        hits      = {hit_t, hit_a2, hit_a1};
        ens       = {en_t, en_a2, en_a1};
    end

    // Event of a sequence slot code.
    function automatic logic slot_hit(input logic [1:0] code, input logic [2:0] h);
        logic r;
        r = 1'b0;
        case (code)
            `HBEU_SLOT_A1: r = h[0];
            `HBEU_SLOT_A2: r = h[1];
            `HBEU_SLOT_T:  r = h[2];
            default:       r = 1'b0;
        endcase
        return r;
    endfunction : slot_hit

    // ------------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------------
    logic [1:0]  cur_slot;
    logic [1:0]  nxt_slot;
    logic        comb_ev;
    logic        seq_done;
    logic        tick;
    logic        advance;
    logic        tmr_fire;
    logic        running;
    logic [4:0]  src_hit;
    logic [5:0]  ev_set;
    logic [5:0]  rd_clr;
    logic [15:0] wr_count;

    always_comb
    begin
        s_d      = s_q;
        mem_we   = 1'b0;
        mem_wa   = s_q.rom_addr;
        mem_wd   = bus.wdata[9:0];
        comb_ev  = 1'b0;
        seq_done = 1'b0;
        tmr_fire = 1'b0;
        src_hit  = 5'h0_0;
        rd_clr   = 6'h0_0;
        running  = (s_q.phase == ST_RUN);
        cur_slot = s_q.order[{s_q.seq_step, 1'b0} +: 2];
        nxt_slot = (s_q.seq_step == 2'h2) ? `HBEU_SLOT_NONE
                 : s_q.order[{s_q.seq_step + 2'h1, 1'b0} +: 2];
        wr_count = (bus.wdata[15:0] < `HBEU_TCOUNT_MIN) ? `HBEU_TCOUNT_MIN
                 : bus.wdata[15:0];

        // Fixed 10 us time base, always running so ticks stay evenly spaced.
        // A run does not restart it, so the first tick of a run may come early.
        tick = (s_q.tick_cnt == TICK_LAST);
        s_d.tick_cnt = tick ? 7'h0_0 : s_q.tick_cnt + 7'h0_1;
        advance = s_q.ctrl[`HBEU_CTRL_CYCSRC] ? tgt.mcu_cycle
                : tick;

        // Combined hardware break event.
        // AND with no component enabled never fires.
        case (comb_mode)
            COMB_AND: comb_ev = (ens != 3'h0) && ((hits & ens) == ens);
            COMB_OR:  comb_ev = |(hits & ens);
            COMB_SEQ:
            begin
                // Each slot must be seen in turn; a none slot ends the list.
                if (running && cur_slot != `HBEU_SLOT_NONE && slot_hit(cur_slot, hits))
                begin
                    if (nxt_slot == `HBEU_SLOT_NONE)
                    begin
                        seq_done   = 1'b1;
                        s_d.seq_step = 2'h0;
                    end
                    else
                    begin
                        s_d.seq_step = s_q.seq_step + 2'h1;
                    end
                end
                comb_ev = seq_done;
            end
            default:  comb_ev = 1'b0;
        endcase

        // Break timer.
        // The count expires on its Nth advance; the write clamp keeps N at two or more.
        if (running && s_q.tmr_run && advance)
        begin
            if (s_q.tmr_cnt <= 16'h0_001)
            begin
                s_d.tmr_cnt = 16'h0_000;
                s_d.tmr_run = 1'b0;
                s_d.tmr_exp = 1'b1;
                tmr_fire    = 1'b1;
            end
            else
            begin
                s_d.tmr_cnt = s_q.tmr_cnt - 16'h0_001;
            end
        end
        if (running && tmode == post_event_delay_mode && comb_ev
            && !s_q.tmr_run && !s_q.tmr_exp)
        begin
            s_d.tmr_run = 1'b1;
        end

        // Break sources, any number enabled at once.
        // A halt records every source that hit in its cycle, not just the first.
        if (running)
        begin
            src_hit[0] = s_q.ctrl[`HBEU_CTRL_SRC_BP] && comb_ev;
            src_hit[1] = s_q.ctrl[`HBEU_CTRL_SRC_STK] && (tgt.stk_ovf || tgt.stk_unf);
            src_hit[2] = s_q.ctrl[`HBEU_CTRL_SRC_TEV] && tgt.trace_ev;
            src_hit[3] = s_q.ctrl[`HBEU_CTRL_SRC_TFL] && tgt.trace_full;
            case (tmode)
                timer_off_mode:        src_hit[4] = 1'b0;
                timeout_mode:          src_hit[4] = comb_ev && !s_q.tmr_exp;
                elapsed_run_mode:      src_hit[4] = tmr_fire;
                post_event_delay_mode: src_hit[4] = tmr_fire;
                default:               src_hit[4] = 1'b0;
            endcase
        end

        // Run control and ROM fill.
        case (s_q.phase)
            ST_FILL:
            begin
                mem_we = 1'b1;
                mem_wa = s_q.fill_addr;
                mem_wd = `HBEU_NOP_CODE;
                s_d.fill_addr = s_q.fill_addr + 12'h0_01;
                if (s_q.fill_addr == ROM_LAST)
                begin
                    s_d.phase = ST_IDLE;
                end
            end
            ST_IDLE, ST_HALT:
            begin
                if (tgt.run_start)
                begin
                    // Each start reloads the count, so a new value waits for the next run.
                    s_d.phase    = ST_RUN;
                    s_d.halt     = 1'b0;
                    s_d.cause    = 5'h0_0;
                    s_d.seq_step = 2'h0;
                    s_d.tmr_cnt  = s_q.tcount;
                    s_d.tmr_exp  = 1'b0;
                    s_d.tmr_run  = (tmode == timeout_mode) || (tmode == elapsed_run_mode);
                end
            end
            ST_RUN:
            begin
                if (src_hit != 5'h0_0)
                begin
                    s_d.phase = ST_HALT;
                    s_d.halt  = 1'b1;
                    s_d.cause = src_hit;
                end
            end
            default: s_d.phase = ST_IDLE;
        endcase

        // Register writes.
        if (bus.we)
        begin
            case (bus.addr)
                `HBEU_OFS_CTRL:     s_d.ctrl   = bus.wdata[`HBEU_CTRL_WIDTH-1:0];
                `HBEU_OFS_ORDER:    s_d.order  = bus.wdata[5:0];
                `HBEU_OFS_ADDR1:    s_d.addr1  = bus.wdata[11:0];
                `HBEU_OFS_ADDR2:    s_d.addr2  = bus.wdata[11:0];
                `HBEU_OFS_TCOUNT:   s_d.tcount = wr_count;
                `HBEU_OFS_MASK:     s_d.mask   = bus.wdata[5:0];
                `HBEU_OFS_ROM_ADDR: s_d.rom_addr = bus.wdata[11:0];
                `HBEU_OFS_ROM_DATA:
                begin
                    // Downloads are dropped while the fill pass owns the port.
                    if (s_q.phase != ST_FILL)
                    begin
                        mem_we       = 1'b1;
                        s_d.rom_addr = s_q.rom_addr + 12'h0_01;
                    end
                end
                default: ;
            endcase
        end

        // Register reads; data stand in the next cycle only.
        // Only the status read has a side effect: it clears the sticky bits.
        s_d.rdata = 32'h0000_0000;
        if (bus.re)
        begin
            case (bus.addr)
                `HBEU_OFS_CTRL:     s_d.rdata = 32'(s_q.ctrl);
                `HBEU_OFS_ORDER:    s_d.rdata = 32'(s_q.order);
                `HBEU_OFS_ADDR1:    s_d.rdata = 32'(s_q.addr1);
                `HBEU_OFS_ADDR2:    s_d.rdata = 32'(s_q.addr2);
                `HBEU_OFS_TCOUNT:   s_d.rdata = 32'(s_q.tcount);
                `HBEU_OFS_STATUS:
                begin
                    s_d.rdata = 32'(s_q.status);
                    rd_clr    = 6'h3_F;
                end
                `HBEU_OFS_MASK:     s_d.rdata = 32'(s_q.mask);
                `HBEU_OFS_TIMER:
                    s_d.rdata = {14'h0_000, s_q.tmr_exp, s_q.tmr_run, s_q.tmr_cnt};
                `HBEU_OFS_ROM_ADDR: s_d.rdata = 32'(s_q.rom_addr);
                `HBEU_OFS_RUN:
                    s_d.rdata = {25'h000_0000, s_q.cause, s_q.phase};
                default:            s_d.rdata = 32'h0000_0000;
            endcase
        end

        // Sticky events: a new event wins over the clearing read.
        ev_set = {(s_q.phase == ST_FILL) && (s_d.phase == ST_IDLE), src_hit};
        s_d.status = (s_q.status & ~rd_clr) | ev_set;
        // The interrupt follows the next status, so it rises together with halt.
        s_d.irq    = |(s_d.status & s_q.mask);
        // Busy is a flop of its own so that its pin comes straight from a register.
        s_d.busy   = (s_d.phase == ST_FILL);

        // Words under the fill pass are not yet defined, so the fetch port
        // shows the no-operation code until the pass has finished.
        if (s_q.phase == ST_FILL)
        begin
            s_d.fetch_data = `HBEU_NOP_CODE;
        end
        else
        begin
            s_d.fetch_data = rom_rd;
        end
    end

    // ------------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_q            <= '0;
            s_q.phase      <= ST_FILL;
            s_q.ctrl       <= `HBEU_CTRL_RST;
            s_q.order      <= `HBEU_ORDER_RST;
            s_q.tcount     <= `HBEU_TCOUNT_RST;
            s_q.fetch_data <= `HBEU_NOP_CODE;
            s_q.busy       <= 1'b1;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign rdata      = s_q.rdata;
    assign fetch_data = s_q.fetch_data;
    assign halt       = s_q.halt;
    assign init_busy  = s_q.busy;
    assign irq        = s_q.irq;

endmodule : hbeu_top

/* hbeu_top_properties.sv */
`timescale 1ns/1ps
module hbeu_checker (
    input wire logic                clk,
    input wire logic                reset_n,
    input wire hbeu_pkg::hbeu_bus_t bus,
    input wire logic [31:0]         rdata,
    input wire hbeu_pkg::hbeu_tgt_t tgt,
    input wire logic [9:0]          fetch_data,
    input wire logic                halt,
    input wire logic                init_busy,
    input wire logic                irq
);
    import hbeu_pkg::*;

    // ------------------------------------------------------------------
    // Shadow state.
    // ------------------------------------------------------------------
    // Control, compare address and mask are mirrored from bus writes so
    // that halts from the stack, trace and first-address break sources can be
    // tied to the input that caused them.
    logic [12:0] ctrl_q;
    logic [11:0] addr1_q;
    logic [5:0]  mask_q;
    logic        run_q;
    logic [12:0] busy_q;

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            ctrl_q  <= 13'h0_000;
            addr1_q <= 12'h000;
            mask_q  <= 6'h00;
            run_q   <= 1'b0;
            busy_q  <= 13'h0_000;
        end
        else
        begin
            if (bus.we && bus.addr == 8'h00)
                ctrl_q <= bus.wdata[12:0];
            if (bus.we && bus.addr == 8'h08)
                addr1_q <= bus.wdata[11:0];
            if (bus.we && bus.addr == 8'h18)
                mask_q <= bus.wdata[5:0];
            if (tgt.run_start && !init_busy)
                run_q <= 1'b1;
            else if (halt)
                run_q <= 1'b0;
            if (init_busy)
                busy_q <= busy_q + 13'h0_001;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    a_fill_length: assert property ($fell(init_busy) |->
        busy_q >= 13'h1_000 && busy_q <= 13'h1_004) else $error("fill length wrong");
    a_fill_quiet: assert property (init_busy |-> !halt && !irq)
        else $error("halt or irq during fill");
    a_src_halts: assert property (run_q && !halt &&
        ((ctrl_q[6] && (tgt.stk_ovf || tgt.stk_unf)) || (ctrl_q[7] && tgt.trace_ev)
        || (ctrl_q[8] && tgt.trace_full)) |=> halt) else $error("source did not halt");
    a_or_break: assert property (run_q && !halt && ctrl_q[1:0] == 2'h1 && ctrl_q[2]
        && ctrl_q[5] && tgt.fetch_valid && tgt.fetch_addr == addr1_q |=> halt)
        else $error("address event did not halt");
    a_no_spurious: assert property (!run_q && !halt |=> !halt)
        else $error("halt while not running");
    a_halt_holds: assert property (halt && !tgt.run_start |=> halt)
        else $error("halt dropped without restart");
    a_halt_release: assert property (halt && tgt.run_start |=> !halt)
        else $error("restart did not clear halt");
    a_rdata_idle: assert property (!bus.re |=> rdata == 32'h0000_0000)
        else $error("read data outside read slot");
    a_irq_masked: assert property (mask_q == 6'h00 |=> !irq)
        else $error("interrupt with empty mask");
    a_irq_clear: assert property (bus.re && bus.addr == 8'h14 && !run_q && !init_busy
        |-> ##2 !irq) else $error("status read did not clear interrupt");
endmodule : hbeu_checker

bind hbeu_top hbeu_checker u_chk (
    .clk        (clk),
    .reset_n    (reset_n),
    .bus        (bus),
    .rdata      (rdata),
    .tgt        (tgt),
    .fetch_data (fetch_data),
    .halt       (halt),
    .init_busy  (init_busy),
    .irq        (irq)
);

/* hbeu_target_model.sv */
`timescale 1ns/1ps
module hbeu_target_model (
    input  wire logic           clk,
    output hbeu_pkg::hbeu_tgt_t tgt
);
    import hbeu_pkg::*;

    // ------------------------------------------------------------------
    // Target side actions.
    // ------------------------------------------------------------------
    // A released fetch address shows the inverse of its last value, so a
    // block that samples it outside the valid cycle sees a wrong address.
    initial tgt = '0;

    task automatic start();
        @(posedge clk);
        tgt.run_start <= 1'b1;
        @(posedge clk);
        tgt.run_start <= 1'b0;
    endtask : start

    task automatic fetch(input logic [11:0] a);
        @(posedge clk);
        tgt.fetch_valid <= 1'b1;
        tgt.fetch_addr  <= a;
        @(posedge clk);
        tgt.fetch_valid <= 1'b0;
        tgt.fetch_addr  <= ~a;
        #1;
    endtask : fetch

    task automatic pulse(input int i);
        @(posedge clk);
        {tgt.stk_ovf, tgt.stk_unf, tgt.trace_ev, tgt.trace_full} <= 4'(4'h8 >> i);
        @(posedge clk);
        {tgt.stk_ovf, tgt.stk_unf, tgt.trace_ev, tgt.trace_full} <= 4'h0;
    endtask : pulse

    task automatic trig(input logic v);
        @(posedge clk);
        tgt.trig <= v;
    endtask : trig

    // A gap above zero models a slow target with idle clocks between cycles.
    task automatic cycles(input int n, input int gap);
        for (int i = 0; i < n; i++)
        begin
            @(posedge clk);
            tgt.mcu_cycle <= 1'b1;
            @(posedge clk);
            tgt.mcu_cycle <= 1'b0;
            repeat (gap) @(posedge clk);
        end
    endtask : cycles
endmodule : hbeu_target_model

/* tb_hardware_break_event_unit.sv */
`timescale 1ns/1ps
module tb_hardware_break_event_unit;
    import hbeu_pkg::*;
    logic        clk;
    logic        reset_n;
    hbeu_bus_t   bus;
    logic [31:0] rdata;
    hbeu_tgt_t   tgt;
    logic [9:0]  fetch_data;
    logic        halt;
    logic        init_busy;
    logic        irq;
    logic [31:0] d;
    int          n_errors    = 0;
    int          comparisons = 0;
    int          cycles_run  = 0;
    logic [12:0] sb [4]      = '{13'h0_040, 13'h0_040, 13'h0_080, 13'h0_100};
    logic [31:0] st [4]      = '{32'h0000_0002, 32'h0000_0002, 32'h0000_0004, 32'h0000_0008};

    hbeu_top dut (.clk(clk), .reset_n(reset_n), .bus(bus), .rdata(rdata), .tgt(tgt),
        .fetch_data(fetch_data), .halt(halt), .init_busy(init_busy), .irq(irq));
    hbeu_target_model mcu (.clk(clk), .tgt(tgt));

    // ------------------------------------------------------------------
    // Clock, watchdog and shared tasks.
    // ------------------------------------------------------------------
    initial clk = 1'b0;
    always #50 clk = ~clk;

    always @(posedge clk)
    begin
        cycles_run = cycles_run + 1;
        if (cycles_run == 20000)
        begin
            n_errors++;
            finish_test();
        end
    end

    task automatic finish_test();
        if (n_errors == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : finish_test

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            n_errors++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        bus <= '{wdata: v, addr: a, we: 1'b1, re: 1'b0};
        @(posedge clk);
        bus <= '0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge clk);
        bus <= '{wdata: 32'h0000_0000, addr: a, we: 1'b0, re: 1'b1};
        @(posedge clk);
        bus <= '0;
        #1;
        v = rdata;
    endtask : rd

    // Clears stale status before each run so a later read shows only its cause.
    task automatic run(input logic [31:0] c);
        wr(8'h00, c);
        rd(8'h14, d);
        mcu.start();
    endtask : run

    task automatic hchk(input logic e);
        repeat (2) @(posedge clk);
        #1;
        chk({31'h0, halt}, {31'h0, e});
    endtask : hchk

    // ------------------------------------------------------------------
    // Scenarios.
    // ------------------------------------------------------------------
    task automatic t_fill();
        for (int i = 0; i < 5000 && init_busy !== 1'b0; i++)
            @(posedge clk);
        chk({31'h0, init_busy}, 32'h0000_0000);
        rd(8'h14, d);
        chk(d, 32'h0000_0020);
        mcu.fetch(12'h000);
        chk({22'h0, fetch_data}, 32'h0000_0000);
        mcu.fetch(12'hFFF);
        chk({22'h0, fetch_data}, 32'h0000_0000);
        wr(8'h20, 32'h0000_0005);
        wr(8'h24, 32'h0000_03FF);
        rd(8'h20, d);
        chk(d, 32'h0000_0006);
        mcu.fetch(12'h005);
        chk({22'h0, fetch_data}, 32'h0000_03FF);
        mcu.fetch(12'h006);
        chk({22'h0, fetch_data}, 32'h0000_0000);
    endtask : t_fill

    task automatic t_regs();
        rd(8'h04, d);
        chk(d, 32'h0000_003C);
        wr(8'h10, 32'h0000_0000);
        rd(8'h10, d);
        chk(d, 32'h0000_0002);
        wr(8'h10, 32'hFFFF_FFFF);
        rd(8'h10, d);
        chk(d, 32'h0000_FFFF);
        wr(8'hFC, 32'hFFFF_FFFF);
        rd(8'hFC, d);
        chk(d, 32'h0000_0000);
        rd(8'h00, d);
        chk(d, 32'h0000_0000);
    endtask : t_regs

    task automatic t_comb();
        wr(8'h08, 32'h0000_0123);
        wr(8'h0C, 32'h0000_0456);
        run(32'h0000_0074);
        mcu.fetch(12'h123);
        hchk(1'b0);
        mcu.trig(1'b1);
        mcu.fetch(12'h123);
        hchk(1'b1);
        mcu.trig(1'b0);
        run(32'h0000_002D);
        mcu.fetch(12'h456);
        hchk(1'b1);
        rd(8'h14, d);
        chk(d, 32'h0000_0001);
        run(32'h0000_002D);
        mcu.fetch(12'h123);
        hchk(1'b1);
        wr(8'h04, 32'h0000_0021);
        run(32'h0000_0062);
        mcu.fetch(12'h456);
        mcu.pulse(0);
        hchk(1'b1);
        run(32'h0000_0062);
        mcu.fetch(12'h123);
        mcu.trig(1'b1);
        mcu.trig(1'b0);
        hchk(1'b0);
        mcu.fetch(12'h456);
        mcu.fetch(12'h123);
        mcu.trig(1'b1);
        mcu.trig(1'b0);
        hchk(1'b1);
        run(32'h0000_1031);
        hchk(1'b1);
        mcu.trig(1'b1);
        run(32'h0000_1031);
        hchk(1'b0);
        mcu.trig(1'b0);
        hchk(1'b1);
    endtask : t_comb

    task automatic t_src();
        int o;
        for (int i = 0; i < 4; i++)
        begin
            o = (i < 2) ? 3 : 0;
            run({19'h0, sb[o]});
            mcu.pulse(i);
            hchk(1'b0);
            mcu.pulse(o);
            hchk(1'b1);
            run(32'h0000_01C0);
            mcu.pulse(i);
            hchk(1'b1);
            rd(8'h14, d);
            chk(d, st[i]);
        end
        wr(8'h18, 32'h0000_0002);
        run(32'h0000_0040);
        mcu.pulse(1);
        hchk(1'b1);
        chk({31'h0, irq}, 32'h0000_0001);
        rd(8'h28, d);
        chk(d, 32'h0000_000B);
        rd(8'h14, d);
        repeat (3) @(posedge clk);
        chk({31'h0, irq}, 32'h0000_0000);
        wr(8'h18, 32'h0000_0000);
    endtask : t_src

    task automatic t_timer();
        wr(8'h10, 32'h0000_0002);
        run(32'h0000_0845);
        mcu.cycles(5, 0);
        mcu.fetch(12'h123);
        hchk(1'b0);
        mcu.pulse(0);
        hchk(1'b1);
        for (int k = 0; k < 4; k++)
        begin
            if (k % 2 == 0)
                wr(8'h10, 32'(2 + k / 2));
            run(32'h0000_0C40);
            mcu.cycles(1 + k / 2, k);
            hchk(1'b0);
            mcu.cycles(1, 0);
            hchk(1'b1);
        end
        run(32'h0000_0E05);
        mcu.cycles(3, 0);
        mcu.fetch(12'h123);
        mcu.cycles(2, 0);
        hchk(1'b0);
        mcu.cycles(1, 0);
        hchk(1'b1);
        rd(8'h1C, d);
        chk(d, 32'h0002_0000);
        run(32'h0000_0A45);
        mcu.cycles(2, 0);
        mcu.fetch(12'h123);
        hchk(1'b1);
        run(32'h0000_0A45);
        mcu.cycles(3, 0);
        mcu.fetch(12'h123);
        hchk(1'b0);
        mcu.pulse(0);
        wr(8'h10, 32'h0000_0002);
        run(32'h0000_0440);
        repeat (90) @(posedge clk);
        chk({31'h0, halt}, 32'h0000_0000);
        for (int i = 0; i < 130 && halt !== 1'b1; i++)
            @(posedge clk);
        chk({31'h0, halt}, 32'h0000_0001);
    endtask : t_timer

    initial
    begin
        reset_n = 1'b0;
        bus     = '0;
        repeat (5) @(posedge clk);
        reset_n <= 1'b1;
        t_fill();
        t_regs();
        t_comb();
        t_src();
        t_timer();
        finish_test();
    end
endmodule : tb_hardware_break_event_unit
